//--- design/ccr_top.sv
`timescale 1ns/10ps
`default_nettype none

module ccr_top
  import ccr_pkg::*;
#(
  parameter logic             APST_CAPABLE = 1'b1,
  parameter logic [EXP_W-1:0] SQ_MAX_LIMIT = SQ_MAX_RST,
  parameter logic [EXP_W-1:0] CQ_MAX_LIMIT = CQ_MAX_RST,
  parameter logic [CNT_W-1:0] NS_MAX       = NS_MAX_DEF
) (
  input  wire logic              clk,
  input  wire logic              srst,
  // Register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              we,
  input  wire logic              re,
  output logic      [DATA_W-1:0] rdata,
  // Record byte port
  input  wire logic              rec_rd,
  input  wire logic [REC_AW-1:0] rec_addr,
  output logic      [BYTE_W-1:0] rec_data,
  output logic                   rec_valid,
  output logic                   rec_hit,
  // Field values
  output logic                   auto_power_transition_attr_en,
  output logic      [BYTE_W-1:0] submit_entry_size_field,
  output logic      [BYTE_W-1:0] complete_entry_size_field,
  output logic      [CNT_W-1:0]  namespace_count
);

  // ****************************************
  // Parameter checks
  // ****************************************
  generate
    if (NS_MAX < NS_FIRST_ID) begin : g_bad_ns
      $error("ccr_top: NS_MAX must be at least one");
    end
    if (CNT_RST > NS_MAX) begin : g_bad_rst
      $error("ccr_top: NS_MAX below reset namespace count");
    end
    // Limits may not undercut the required entry sizes
    if (SQ_MAX_LIMIT < SQ_REQ_EXP) begin : g_bad_sq
      $error("ccr_top: SQ_MAX_LIMIT below required exponent");
    end
    if (CQ_MAX_LIMIT < CQ_REQ_EXP) begin : g_bad_cq
      $error("ccr_top: CQ_MAX_LIMIT below required exponent");
    end
    // Reset maxima must fit under the limits
    if (SQ_MAX_RST > SQ_MAX_LIMIT) begin : g_bad_sq_rst
      $error("ccr_top: SQ_MAX_LIMIT below reset exponent");
    end
    if (CQ_MAX_RST > CQ_MAX_LIMIT) begin : g_bad_cq_rst
      $error("ccr_top: CQ_MAX_LIMIT below reset exponent");
    end
  endgenerate

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic              apst;
    logic [CNT_W-1:0]  ns_count;
    logic [REC_AW-1:0] rec_ptr;
    logic [DATA_W-1:0] rdata;
    logic [BYTE_W-1:0] rec_data;
    logic              rec_valid;
    logic              rec_hit;
  } ccr_top_s;

  localparam ccr_top_s ST_RST = '{
    apst:      1'b0,
    ns_count:  CNT_RST,
    rec_ptr:   '0,
    rdata:     '0,
    rec_data:  '0,
    rec_valid: 1'b0,
    rec_hit:   1'b0
  };

  ccr_top_s st_r;
  ccr_top_s st_nxt;

  // ****************************************
  // Sub-block wiring
  // ****************************************
  logic [EXP_W-1:0] sq_max;
  logic [EXP_W-1:0] cq_max;
  logic             sq_wr;
  logic             cq_wr;
  logic             ns_query;
  logic             ns_done;
  logic             ns_valid;
  logic [BYTE_W-1:0] sq_byte;
  logic [BYTE_W-1:0] cq_byte;

  assign sq_wr    = we && (addr == REG_SQ_SIZE);
  assign cq_wr    = we && (addr == REG_CQ_SIZE);
  assign ns_query = we && (addr == REG_NS_QUERY);
  assign sq_byte  = {sq_max, SQ_REQ_EXP};
  assign cq_byte  = {cq_max, CQ_REQ_EXP};

  ccr_exp_reg #(
    .REQ_EXP   (SQ_REQ_EXP),
    .MAX_LIMIT (SQ_MAX_LIMIT),
    .RST_EXP   (SQ_MAX_RST)
  ) u_sq_exp (
    .clk     (clk),
    .srst    (srst),
    .wr_en   (sq_wr),
    .wr_exp  (wdata[EXP_MAX_LSB +: EXP_W]),
    .max_exp (sq_max)
  );

  ccr_exp_reg #(
    .REQ_EXP   (CQ_REQ_EXP),
    .MAX_LIMIT (CQ_MAX_LIMIT),
    .RST_EXP   (CQ_MAX_RST)
  ) u_cq_exp (
    .clk     (clk),
    .srst    (srst),
    .wr_en   (cq_wr),
    .wr_exp  (wdata[EXP_MAX_LSB +: EXP_W]),
    .max_exp (cq_max)
  );

  ccr_ns_check u_ns_check (
    .clk             (clk),
    .srst            (srst),
    .query           (ns_query),
    .query_id        (wdata[CNT_W-1:0]),
    .namespace_count (st_r.ns_count),
    .done            (ns_done),
    .valid           (ns_valid)
  );

  // ****************************************
  // Record byte builder
  // ****************************************
  function automatic logic [BYTE_W-1:0] rec_byte(
    input logic [REC_AW-1:0] a,
    input logic              apst,
    input logic [BYTE_W-1:0] sqb,
    input logic [BYTE_W-1:0] cqb,
    input logic [CNT_W-1:0]  cnt
  );
    logic [BYTE_W-1:0] b;
    b = '0;
    case (a)
      REC_APST: begin
        b = {{(BYTE_W-1){1'b0}}, apst};
      end
      REC_SQ_SIZE: begin
        b = sqb;
      end
      REC_CQ_SIZE: begin
        b = cqb;
      end
      REC_CNT_B0: begin
        b = cnt[0*BYTE_W +: BYTE_W];
      end
      REC_CNT_B1: begin
        b = cnt[1*BYTE_W +: BYTE_W];
      end
      REC_CNT_B2: begin
        b = cnt[2*BYTE_W +: BYTE_W];
      end
      REC_CNT_B3: begin
        b = cnt[3*BYTE_W +: BYTE_W];
      end
      default: begin
        b = '0;
      end
    endcase
    return b;
  endfunction

  // ****************************************
  // Ownership of a record byte
  // ****************************************
  function automatic logic rec_owned(input logic [REC_AW-1:0] a);
    return (a >= REC_APST) && (a <= REC_CNT_B3);
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt           = st_r;
    st_nxt.rdata     = '0;
    st_nxt.rec_valid = 1'b0;

    // Register writes
    if (we) begin
      case (addr)
        REG_CTRL: begin
          st_nxt.apst = wdata[CTRL_APST_BIT] & APST_CAPABLE;
        end
        REG_NS_CNT: begin
          if (wdata[CNT_W-1:0] > NS_MAX) begin
            st_nxt.ns_count = NS_MAX;
          end else begin
            st_nxt.ns_count = wdata[CNT_W-1:0];
          end
        end
        REG_REC_ADDR: begin
          st_nxt.rec_ptr = wdata[REC_AW-1:0];
        end
        default: begin
          st_nxt.rec_ptr = st_r.rec_ptr;
        end
      endcase
    end

    // Register reads, answer in next cycle only
    if (re) begin
      case (addr)
        REG_CTRL: begin
          st_nxt.rdata = DATA_W'(st_r.apst);
        end
        REG_SQ_SIZE: begin
          st_nxt.rdata = DATA_W'(sq_byte);
        end
        REG_CQ_SIZE: begin
          st_nxt.rdata = DATA_W'(cq_byte);
        end
        REG_NS_CNT: begin
          st_nxt.rdata = DATA_W'(st_r.ns_count);
        end
        REG_REC_ADDR: begin
          st_nxt.rdata = DATA_W'(st_r.rec_ptr);
        end
        REG_REC_DATA: begin
          st_nxt.rdata   = DATA_W'(rec_byte(st_r.rec_ptr, st_r.apst, sq_byte, cq_byte, st_r.ns_count));
          // Pointer advances past the end of the record, wrapping only at the top of the 10-bit address
          st_nxt.rec_ptr = st_r.rec_ptr + REC_ONE;
        end
        REG_NS_STAT: begin
          st_nxt.rdata[NS_ST_DONE]  = ns_done;
          st_nxt.rdata[NS_ST_VALID] = ns_valid;
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end

    // Record byte port
    if (rec_rd) begin
      st_nxt.rec_valid = 1'b1;
      st_nxt.rec_hit   = rec_owned(rec_addr);
      st_nxt.rec_data  = rec_byte(rec_addr, st_r.apst, sq_byte, cq_byte, st_r.ns_count);
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata                         = st_r.rdata;
  assign rec_data                      = st_r.rec_data;
  assign rec_valid                     = st_r.rec_valid;
  assign rec_hit                       = st_r.rec_hit;
  assign auto_power_transition_attr_en = st_r.apst;
  assign submit_entry_size_field       = sq_byte;
  assign complete_entry_size_field     = cq_byte;
  assign namespace_count               = st_r.ns_count;

endmodule

`default_nettype wire

//--- inc/ccr_pkg.sv
package ccr_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ****************************************
  // Software register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_SQ_SIZE  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CQ_SIZE  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_NS_CNT   = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_REC_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] REG_REC_DATA = 8'h14;
  localparam logic [ADDR_W-1:0] REG_NS_QUERY = 8'h18;
  localparam logic [ADDR_W-1:0] REG_NS_STAT  = 8'h1c;

  // ****************************************
  // Field layouts
  // ****************************************
  localparam int CTRL_APST_BIT = 0;
  localparam int EXP_W         = 4;
  localparam int EXP_MAX_LSB   = 4;
  localparam int NS_ST_DONE    = 0;
  localparam int NS_ST_VALID   = 1;
  localparam int CNT_W         = 32;
  localparam int BYTE_W        = 8;

  // ****************************************
  // Capability record byte offsets
  // ****************************************
  localparam int REC_AW = 10;
  localparam logic [REC_AW-1:0] REC_APST   = 10'h109;
  localparam logic [REC_AW-1:0] REC_RSV_LO = 10'h10a;
  localparam logic [REC_AW-1:0] REC_SQ_SIZE = 10'h200;
  localparam logic [REC_AW-1:0] REC_CQ_SIZE = 10'h201;
  localparam logic [REC_AW-1:0] REC_CNT_B0  = 10'h204;
  localparam logic [REC_AW-1:0] REC_CNT_B1  = 10'h205;
  localparam logic [REC_AW-1:0] REC_CNT_B2  = 10'h206;
  localparam logic [REC_AW-1:0] REC_CNT_B3  = 10'h207;
  localparam logic [REC_AW-1:0] REC_ONE    = 10'h001;

  // ****************************************
  // Entry size exponents and reset values
  // ****************************************
  localparam logic [EXP_W-1:0] SQ_REQ_EXP = 4'h6;
  localparam logic [EXP_W-1:0] SQ_MAX_RST = 4'h6;
  localparam logic [EXP_W-1:0] CQ_REQ_EXP = 4'h4;
  localparam logic [EXP_W-1:0] CQ_MAX_RST = 4'h4;
  localparam logic [CNT_W-1:0] CNT_RST     = 32'h0000_0001;
  localparam logic [CNT_W-1:0] NS_FIRST_ID = 32'h0000_0001;
  localparam logic [CNT_W-1:0] NS_MAX_DEF  = 32'h0000_0400;

endpackage

//--- design/ccr_exp_reg.sv
`timescale 1ns/10ps
`default_nettype none

module ccr_exp_reg
  import ccr_pkg::*;
#(
  parameter logic [EXP_W-1:0] REQ_EXP   = SQ_REQ_EXP,
  parameter logic [EXP_W-1:0] MAX_LIMIT = SQ_MAX_RST,
  parameter logic [EXP_W-1:0] RST_EXP   = SQ_MAX_RST
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             wr_en,
  input  wire logic [EXP_W-1:0] wr_exp,
  output logic      [EXP_W-1:0] max_exp
);

  typedef struct packed {
    logic [EXP_W-1:0] max_exp;
  } ccr_exp_s;

  ccr_exp_s st_r;
  ccr_exp_s st_nxt;

  generate
    if (!(REQ_EXP <= RST_EXP && RST_EXP <= MAX_LIMIT)) begin : g_bad
      $error("ccr_exp_reg: need REQ_EXP <= RST_EXP <= MAX_LIMIT");
    end
  endgenerate

  // ****************************************
  // Clamped maximum exponent
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    if (wr_en) begin
      if (wr_exp < REQ_EXP) begin
        st_nxt.max_exp = REQ_EXP;
      end else if (wr_exp > MAX_LIMIT) begin
        st_nxt.max_exp = MAX_LIMIT;
      end else begin
        st_nxt.max_exp = wr_exp;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '{max_exp: RST_EXP};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign max_exp = st_r.max_exp;

endmodule

`default_nettype wire

//--- design/ccr_ns_check.sv
`timescale 1ns/10ps
`default_nettype none

module ccr_ns_check
  import ccr_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire logic            query,
  input  wire logic [CNT_W-1:0] query_id,
  input  wire logic [CNT_W-1:0] namespace_count,
  output logic                 done,
  output logic                 valid
);

  typedef struct packed {
    logic done;
    logic valid;
  } ccr_nsc_s;

  ccr_nsc_s st_r;
  ccr_nsc_s st_nxt;

  // ****************************************
  // Identifier lookup
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    if (query) begin
      st_nxt.done  = 1'b1;
      st_nxt.valid = (query_id >= NS_FIRST_ID) && (query_id <= namespace_count);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '{done: 1'b0, valid: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done  = st_r.done;
  assign valid = st_r.valid;

endmodule

`default_nettype wire

//--- dv/ccr_chk.sv
`timescale 1ns/10ps
`default_nettype none
module ccr_chk
  import ccr_pkg::*;
#(
  parameter logic [EXP_W-1:0] SQ_MAX_LIMIT = 4'h6,
  parameter logic [EXP_W-1:0] CQ_MAX_LIMIT = 4'h4,
  parameter logic [CNT_W-1:0] NS_MAX       = NS_MAX_DEF
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              we,
  input wire logic              rec_rd,
  input wire logic [REC_AW-1:0] rec_addr,
  input wire logic [BYTE_W-1:0] rec_data,
  input wire logic              auto_power_transition_attr_en,
  input wire logic [BYTE_W-1:0] submit_entry_size_field,
  input wire logic [BYTE_W-1:0] complete_entry_size_field,
  input wire logic [CNT_W-1:0]  namespace_count
);
  // ****
  // Field checks
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  apst_byte_a: assert property (rec_rd && rec_addr == REC_APST |=>
    rec_data == {7'h0, $past(auto_power_transition_attr_en)}) else $error("apst byte");
  sq_req_a: assert property (submit_entry_size_field[3:0] == 4'h6) else $error("sq req");
  sq_max_a: assert property (submit_entry_size_field[7:4] inside {[4'h6:SQ_MAX_LIMIT]})
    else $error("sq max");
  cq_req_a: assert property (complete_entry_size_field[3:0] == 4'h4) else $error("cq req");
  cq_max_a: assert property (complete_entry_size_field[7:4] inside {[4'h4:CQ_MAX_LIMIT]})
    else $error("cq max");
  sq_rec_a: assert property (rec_rd && rec_addr == REC_SQ_SIZE |=> rec_data == $past(submit_entry_size_field))
    else $error("sq byte");
  cq_rec_a: assert property (rec_rd && rec_addr == REC_CQ_SIZE |=> rec_data == $past(complete_entry_size_field))
    else $error("cq byte");
  cnt_rec_a: assert property (rec_rd && rec_addr[9:2] == 8'h81 |=>
    rec_data == BYTE_W'($past(namespace_count) >> {$past(rec_addr[1:0]), 3'h0})) else $error("count byte");
  cnt_wr_a: assert property (we && addr == REG_NS_CNT && wdata <= NS_MAX |=> namespace_count == $past(wdata))
    else $error("count write");
  rst_val_a: assert property ($fell(srst) |-> submit_entry_size_field == 8'h66 &&
    complete_entry_size_field == 8'h44) else $error("reset sizes");
endmodule
bind ccr_top ccr_chk #(.SQ_MAX_LIMIT(SQ_MAX_LIMIT), .CQ_MAX_LIMIT(CQ_MAX_LIMIT), .NS_MAX(NS_MAX)) u_chk (
  .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .we(we), .rec_rd(rec_rd), .rec_addr(rec_addr),
  .rec_data(rec_data), .auto_power_transition_attr_en(auto_power_transition_attr_en),
  .submit_entry_size_field(submit_entry_size_field), .complete_entry_size_field(complete_entry_size_field),
  .namespace_count(namespace_count));
`default_nettype wire

//--- dv/ccr_host.sv
`timescale 1ns/10ps
`default_nettype none
module ccr_host
  import ccr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              go,
  input  wire logic [REC_AW-1:0] go_addr,
  input  wire logic              rec_valid,
  input  wire logic [BYTE_W-1:0] rec_data,
  output logic                   rec_rd,
  output logic      [REC_AW-1:0] rec_addr,
  output logic      [BYTE_W-1:0] got,
  output logic      [EXP_W-1:0]  use_exp,
  output logic                   done
);
  // ****
  // Record reader
  // ****
  always @(posedge clk) begin
    rec_rd <= go & ~srst;
    rec_addr <= go ? go_addr : ~rec_addr;
    done <= rec_valid & ~srst;
    if (rec_valid) begin
      got <= rec_data;
      use_exp <= (rec_data[7:4] > rec_data[3:0]) ? rec_data[7:4] : rec_data[3:0];
    end
  end
endmodule
`default_nettype wire

//--- dv/ccr_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module ccr_top_tb_top
  import ccr_pkg::*;
;
  typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} ccr_row_s;
  ccr_row_s rows [15] = '{'{REG_CTRL, 32'h1, REG_CTRL, 32'h1}, '{REG_SQ_SIZE, 32'h70, REG_SQ_SIZE, 32'h76},
    '{REG_SQ_SIZE, 32'hf0, REG_SQ_SIZE, 32'h86}, '{REG_SQ_SIZE, 32'h20, REG_SQ_SIZE, 32'h66},
    '{REG_CQ_SIZE, 32'h50, REG_CQ_SIZE, 32'h54}, '{REG_CQ_SIZE, 32'hf0, REG_CQ_SIZE, 32'h64},
    '{REG_CQ_SIZE, 32'h0, REG_CQ_SIZE, 32'h44}, '{REG_NS_CNT, 32'hffff_ffff, REG_NS_CNT, 32'h0102_0304},
    '{REG_REC_ADDR, 32'h109, REG_REC_DATA, 32'h1}, '{REG_REC_ADDR, 32'h204, REG_REC_DATA, 32'h4},
    '{REG_NS_QUERY, 32'h0, REG_NS_STAT, 32'h1}, '{REG_NS_QUERY, 32'h1, REG_NS_STAT, 32'h3},
    '{REG_NS_QUERY, 32'h0102_0304, REG_NS_STAT, 32'h3}, '{REG_NS_QUERY, 32'h0102_0305, REG_NS_STAT, 32'h1},
    '{8'h40, 32'h5, 8'h40, 32'h0}};
  logic [9:0] ra [11] = '{10'h109, 10'h10a, 10'h1ff, 10'h200, 10'h201, 10'h202, 10'h203, 10'h204, 10'h205,
    10'h206, 10'h207};
  logic [7:0] rx [11] = '{8'h1, 8'h0, 8'h0, 8'h86, 8'h64, 8'h0, 8'h0, 8'h4, 8'h3, 8'h2, 8'h1};
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic        go = 1'b0;
  logic [9:0]  go_addr = 10'h0;
  logic [31:0] rdata, got, ns_cnt;
  logic [9:0]  rec_addr;
  logic [7:0]  rec_data, hgot, sq_f, cq_f;
  logic        rec_rd, rec_valid, rec_hit, apst, hdone;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  ccr_top #(.APST_CAPABLE(1'b1), .SQ_MAX_LIMIT(4'h8), .CQ_MAX_LIMIT(4'h6), .NS_MAX(32'h0102_0304)) DUT (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata), .rec_rd(rec_rd),
    .rec_addr(rec_addr), .rec_data(rec_data), .rec_valid(rec_valid), .rec_hit(rec_hit),
    .auto_power_transition_attr_en(apst), .submit_entry_size_field(sq_f), .complete_entry_size_field(cq_f),
    .namespace_count(ns_cnt));
  ccr_host u_host (.clk(clk), .srst(srst), .go(go), .go_addr(go_addr), .rec_valid(rec_valid),
    .rec_data(rec_data), .rec_rd(rec_rd), .rec_addr(rec_addr), .got(hgot), .use_exp(), .done(hdone));
  // ****
  // Bus tasks
  // ****
  always #2 clk = ~clk;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic rd_rec(input logic [9:0] a);
    @(posedge clk);
    go <= 1'b1;
    go_addr <= a;
    @(posedge clk);
    go <= 1'b0;
    for (int k = 0; k < 8 && hdone !== 1'b1; k++) @(negedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      complete_run();
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 15; i++) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, got);
      `CHK("row", rows[i].ex, got)
    end
    $display("test rows done");
    wr(REG_SQ_SIZE, 32'h80);
    wr(REG_CQ_SIZE, 32'h60);
    @(negedge clk);
    `CHK("sq field", 8'h86, sq_f)
    `CHK("cq field", 8'h64, cq_f)
    `CHK("count", 32'h0102_0304, ns_cnt)
    for (int i = 0; i < 11; i++) begin
      rd_rec(ra[i]);
      `CHK("record byte", rx[i], hgot)
      `CHK("record hit", 1'b1, rec_hit)
    end
    wr(REG_CTRL, 32'h0);
    rd_rec(REC_APST);
    `CHK("apst off", 8'h0, hgot)
    rd_rec(10'h208);
    `CHK("outside byte", 8'h0, hgot)
    `CHK("outside hit", 1'b0, rec_hit)
    wr(REG_NS_CNT, 32'h5);
    rd(REG_NS_CNT, got);
    `CHK("count write", 32'h5, got)
    wr(REG_NS_CNT, 32'h0);
    wr(REG_NS_QUERY, 32'h1);
    rd(REG_NS_STAT, got);
    `CHK("no namespaces", 32'h1, got)
    $display("test record done");
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(REG_SQ_SIZE, got);
    `CHK("sq reset", 32'h66, got)
    rd(REG_CQ_SIZE, got);
    `CHK("cq reset", 32'h44, got)
    $display("test reset done");
    complete_run();
  end
endmodule
`default_nettype wire
